/* File: tmsc_top.sv */
// Purpose: Trim command receiver, reset control, diagnostics and timing.
// Assumes: clk stands for the internal oscillator; pins arrive unsynced.
// Notes:   Bit clock edges must be far slower than clk for the crossing.
// Functional notes
// - Offset trim for each of two channels starts only by serial command.
// - Five command bits follow, sampled on rising bit clock edges.
// - Select rises in fifth clock-high phase, then clock falls; frame accepted.
// - Pattern 00010 trims channel 1, pattern 00100 trims channel 2.
// - All-zero completed frame leaves trim mode for either channel.
// - Only a complete correctly closed frame changes the mode.
// - Any reset ends trim mode and restarts initialisation.
// - During trim with changing input, test output carries a square wave.
// - Supply supervision reset releases at safe level, then initialisation begins.
// - External reset forces reset anytime, overriding supply supervision.
// - External reset input is active high.
// - Both channels below 15 mV flags lost magnet and diagnostic output.
// - All logic but the bit sampler runs from the internal oscillator; the sampler runs on the bit clock.
// - New angle result every 0.26 ms, scaling with oscillator period.
// - Output settles to 95 percent in 0.6 ms, 1.2 ms after steps.
`timescale 1ns/1ps
module tmsc_top import tmsc_pkg::*; #(
  parameter int unsigned UPDATE_CYCLES = UPDATE_CYC_DEF,
  parameter int unsigned BAND_CYCLES   = BAND_CYC_DEF,
  parameter int unsigned STEP_CYCLES   = STEP_CYC_DEF,
  parameter int unsigned SAMPLE_W      = 16,
  parameter int unsigned LSB_UV        = LSB_UV_DEF,
  parameter int unsigned STEP_THR      = STEP_THR_DEF
) (
  // Oscillator clock and power-on reset.
  input  wire logic                       clk,
  input  wire logic                       reset,
  // Reset pins.
  input  wire logic                       external_reset_input,
  input  wire logic                       supply_ok,
  // Trim interface pins.
  input  wire logic                       trim_select_line,
  input  wire logic                       trim_bit_clk,
  // Offset-corrected sensor samples and computed angle.
  input  wire logic signed [SAMPLE_W-1:0] sens1_sample,
  input  wire logic signed [SAMPLE_W-1:0] sens2_sample,
  input  wire logic                       sample_valid,
  input  wire logic [ANGLE_W-1:0]         angle_in,
  // Mode outputs.
  output logic                            trim_ch1_ff,
  output logic                            trim_ch2_ff,
  output logic                            frame_done_ff,
  output logic                            test_out_ff,
  // Status and result outputs.
  output logic                            init_busy_ff,
  output logic                            lost_magnet_ff,
  output logic                            update_ff,
  output logic                            settled_ff,
  output logic [ANGLE_W-1:0]              out_code_ff
);

  // Derived widths and the lost magnet threshold in sample counts.
  localparam int unsigned UPD_W   = $clog2(UPDATE_CYCLES + 1);
  localparam int unsigned SET_W   = $clog2(STEP_CYCLES + BAND_CYCLES + 1);
  localparam int unsigned INIT_W  = $clog2(INIT_CYCLES + 1);
  localparam int unsigned THR_CNT = LOST_MV * 1000 / LSB_UV;
  localparam logic [SAMPLE_W-1:0] LOST_THR = SAMPLE_W'(THR_CNT);
  localparam logic [UPD_W-1:0]    UPD_LAST = UPD_W'(UPDATE_CYCLES - 1);
  localparam logic [SET_W-1:0]    BAND_LD  = SET_W'(BAND_CYCLES);
  localparam logic [SET_W-1:0]    STEP_LD  = SET_W'(STEP_CYCLES);
  localparam logic [INIT_W-1:0]   INIT_LD  = INIT_W'(INIT_CYCLES);
  localparam logic [ANGLE_W-1:0]  STEP_LIM = ANGLE_W'(STEP_THR);

  // Two-stage synchronisers for every pin, plus an edge history stage on select, bit clock and toggle.
  logic ext_meta_ff, ext_sync_ff;
  logic sup_meta_ff, sup_sync_ff;
  logic sel_meta_ff, sel_sync_ff, sel_prev_ff;
  logic bck_meta_ff, bck_sync_ff, bck_prev_ff;
  logic tgl_meta_ff, tgl_sync_ff, tgl_prev_ff;
  logic core_rst_ff;

  // Frame receiver.
  tmsc_state_t        state_ff;
  logic [CMD_W-1:0]   cmd_ff;
  logic [2:0]         bit_cnt_ff;

  // Measurement side.
  logic [INIT_W-1:0]  init_cnt_ff;
  logic [UPD_W-1:0]   upd_cnt_ff;
  logic [SET_W-1:0]   settle_cnt_ff;
  logic [ANGLE_W-1:0] angle_ff;
  logic               sign_prev_ff;

  tmsc_link_if lnk ();

  // The bit sampler lives on the programmer's clock.
  tmsc_link_cap u_cap (
    .trim_bit_clk     (trim_bit_clk),
    .trim_select_line (trim_select_line),
    .lnk              (lnk)
  );

  assign lnk.link_rst = core_rst_ff;

  // Pin synchronisers; the first stage is never read by logic.
  always_ff @(posedge clk) begin
    ext_meta_ff <= external_reset_input;
    ext_sync_ff <= ext_meta_ff;
    sup_meta_ff <= supply_ok;
    sup_sync_ff <= sup_meta_ff;
    sel_meta_ff <= trim_select_line;
    sel_sync_ff <= sel_meta_ff;
    sel_prev_ff <= sel_sync_ff;
    bck_meta_ff <= trim_bit_clk;
    bck_sync_ff <= bck_meta_ff;
    bck_prev_ff <= bck_sync_ff;
    tgl_meta_ff <= lnk.edge_tgl;
    tgl_sync_ff <= tgl_meta_ff;
    tgl_prev_ff <= tgl_sync_ff;
  end

  // Combined core reset. A high external pin wins whatever the supply says.
  always_ff @(posedge clk) begin
    core_rst_ff <= reset | ext_sync_ff | ~sup_sync_ff;
  end

  // Protocol events seen in the oscillator domain.
  logic start_evt;
  logic sel_rise;
  logic bck_fall;
  logic bit_evt;
  logic cmd_valid;
  logic [CMD_W-1:0] cmd_full;

  // The link sample is read only after its toggle has crossed; by then it
  // has been stable for two clk cycles and holds for a whole bit period.
  assign start_evt = sel_prev_ff & ~sel_sync_ff & bck_sync_ff;
  assign sel_rise  = ~sel_prev_ff & sel_sync_ff;
  assign bck_fall  = bck_prev_ff & ~bck_sync_ff;
  assign bit_evt   = tgl_sync_ff ^ tgl_prev_ff;
  assign cmd_full  = {cmd_ff[CMD_W-2:0], lnk.sel_sample};
  assign cmd_valid = (cmd_ff == CMD_TRIM_CH1) | (cmd_ff == CMD_TRIM_CH2) |
                     (cmd_ff == CMD_TRIM_EXIT);

  // Frame state machine. A new start during the bit phase restarts it; anything
  // out of order drops the frame without touching the mode.
  always_ff @(posedge clk) begin
    if (core_rst_ff) begin
      state_ff   <= TMSC_IDLE;
      bit_cnt_ff <= 3'h0;
      cmd_ff     <= CMD_TRIM_EXIT;
    end else begin
      case (state_ff)
        TMSC_IDLE: begin
          if (start_evt) begin
            state_ff   <= TMSC_BITS;
            bit_cnt_ff <= 3'h0;
          end
        end
        TMSC_BITS: begin
          if (start_evt) begin
            bit_cnt_ff <= 3'h0;
          end else if (bit_evt) begin
            cmd_ff     <= cmd_full;
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == CMD_BIT_LAST - 3'h1) begin
              state_ff <= TMSC_STOP;
            end
          end else if (sel_rise & bck_sync_ff) begin
            state_ff <= TMSC_IDLE;
          end
        end
        TMSC_STOP: begin
          // Waiting inside the fifth high phase for select to rise.
          if (sel_sync_ff & bck_sync_ff) begin
            state_ff <= TMSC_CLOSE;
          end else if (~bck_sync_ff | bit_evt) begin
            state_ff <= TMSC_IDLE;
          end
        end
        TMSC_CLOSE: begin
          // Frame is taken only on the final falling clock edge.
          if (bck_fall) begin
            state_ff <= TMSC_IDLE;
          end else if (~sel_sync_ff | bit_evt) begin
            state_ff <= TMSC_IDLE;
          end
        end
        default: begin
          state_ff <= TMSC_IDLE;
        end
      endcase
    end
  end

  // Accepted frame: one-cycle pulse once the closing edge is seen.
  logic frame_accept;
  assign frame_accept = (state_ff == TMSC_CLOSE) & bck_fall & sel_sync_ff;

  always_ff @(posedge clk) begin
    if (core_rst_ff) begin
      frame_done_ff <= 1'b0;
    end else begin
      frame_done_ff <= frame_accept & cmd_valid;
    end
  end

  // Trim mode register. Reset of any kind drops back to normal mode.
  always_ff @(posedge clk) begin
    if (core_rst_ff) begin
      trim_ch1_ff <= 1'b0;
      trim_ch2_ff <= 1'b0;
    end else if (frame_accept) begin
      case (cmd_ff)
        CMD_TRIM_CH1: begin
          trim_ch1_ff <= 1'b1;
          trim_ch2_ff <= 1'b0;
        end
        CMD_TRIM_CH2: begin
          trim_ch1_ff <= 1'b0;
          trim_ch2_ff <= 1'b1;
        end
        CMD_TRIM_EXIT: begin
          trim_ch1_ff <= 1'b0;
          trim_ch2_ff <= 1'b0;
        end
        default: begin
          trim_ch1_ff <= trim_ch1_ff;
          trim_ch2_ff <= trim_ch2_ff;
        end
      endcase
    end
  end

  // Test output toggles on each sign change of the channel under trim, so a moving
  // input shows as a square wave and a static one leaves it still.
  logic trim_sign;
  assign trim_sign = trim_ch1_ff ? sens1_sample[SAMPLE_W-1] : sens2_sample[SAMPLE_W-1];

  always_ff @(posedge clk) begin
    if (core_rst_ff) begin
      sign_prev_ff <= 1'b0;
      test_out_ff  <= 1'b0;
    end else if (~(trim_ch1_ff | trim_ch2_ff)) begin
      sign_prev_ff <= trim_sign;
      test_out_ff  <= 1'b0;
    end else if (sample_valid) begin
      sign_prev_ff <= trim_sign;
      if (trim_sign != sign_prev_ff) begin
        test_out_ff <= ~test_out_ff;
      end
    end
  end

  // Initialisation runs for a fixed time after every reset release.
  always_ff @(posedge clk) begin
    if (core_rst_ff) begin
      init_cnt_ff  <= INIT_LD;
      init_busy_ff <= 1'b1;
    end else if (init_cnt_ff != '0) begin
      init_cnt_ff  <= init_cnt_ff - INIT_W'(1);
      init_busy_ff <= 1'b1;
    end else begin
      init_busy_ff <= 1'b0;
    end
  end

  // Magnitudes of both offset-corrected channels.
  logic [SAMPLE_W-1:0] mag1;
  logic [SAMPLE_W-1:0] mag2;
  assign mag1 = sens1_sample[SAMPLE_W-1] ? SAMPLE_W'(-sens1_sample) : SAMPLE_W'(sens1_sample);
  assign mag2 = sens2_sample[SAMPLE_W-1] ? SAMPLE_W'(-sens2_sample) : SAMPLE_W'(sens2_sample);

  // Lost magnet needs both channels weak at once.
  always_ff @(posedge clk) begin
    if (core_rst_ff) begin
      lost_magnet_ff <= 1'b0;
    end else if (sample_valid) begin
      lost_magnet_ff <= (mag1 < LOST_THR) & (mag2 < LOST_THR);
    end
  end

  // Update tick counted on the oscillator, so it scales with its period.
  always_ff @(posedge clk) begin
    if (core_rst_ff | init_busy_ff) begin
      upd_cnt_ff <= '0;
      update_ff  <= 1'b0;
    end else if (upd_cnt_ff == UPD_LAST) begin
      upd_cnt_ff <= '0;
      update_ff  <= 1'b1;
    end else begin
      upd_cnt_ff <= upd_cnt_ff + UPD_W'(1);
      update_ff  <= 1'b0;
    end
  end

  // Angle result latched on each update tick.
  logic               tick;
  logic [ANGLE_W-1:0] delta;
  assign tick  = (upd_cnt_ff == UPD_LAST) & ~init_busy_ff;
  assign delta = (angle_in > angle_ff) ? (angle_in - angle_ff) : (angle_ff - angle_in);

  always_ff @(posedge clk) begin
    if (core_rst_ff) begin
      angle_ff <= ANGLE_RST;
    end else if (tick) begin
      angle_ff <= angle_in;
    end
  end

  // Settling window: a step reloads the long window, a small move raises the
  // count to the short one. The flag is a promise of the bound, not a filter model.
  always_ff @(posedge clk) begin
    if (core_rst_ff) begin
      settle_cnt_ff <= STEP_LD;
      settled_ff    <= 1'b0;
    end else if (tick & (delta > STEP_LIM)) begin
      settle_cnt_ff <= STEP_LD;
      settled_ff    <= 1'b0;
    end else if (tick & (delta != '0) & (settle_cnt_ff < BAND_LD)) begin
      settle_cnt_ff <= BAND_LD;
      settled_ff    <= 1'b0;
    end else if (settle_cnt_ff != '0) begin
      settle_cnt_ff <= settle_cnt_ff - SET_W'(1);
      settled_ff    <= 1'b0;
    end else begin
      settled_ff    <= 1'b1;
    end
  end

  // Output word: the diagnostic code sits above the clipped normal range.
  always_ff @(posedge clk) begin
    if (core_rst_ff) begin
      out_code_ff <= ANGLE_RST;
    end else if (lost_magnet_ff) begin
      out_code_ff <= OUT_DIAG_CODE;
    end else if (angle_ff > OUT_NORM_MAX) begin
      out_code_ff <= OUT_NORM_MAX;
    end else begin
      out_code_ff <= angle_ff;
    end
  end

endmodule

/* File: tmsc_pkg.sv */
// Purpose: Shared constants for the trim mode serial control block.
// Assumes: System clock of 40 MHz; sensor samples are signed counts.
// Notes:   Long cycle counts are only defaults; the top module exposes them.
package tmsc_pkg;

  // System clock rate, used to turn times into cycle counts.
  localparam int unsigned CLK_MHZ          = 40;

  // Command frame layout: five bits, the first received lands in the MSB.
  localparam int unsigned CMD_W            = 5;
  localparam logic [4:0]  CMD_TRIM_CH1     = 5'h02;
  localparam logic [4:0]  CMD_TRIM_CH2     = 5'h04;
  localparam logic [4:0]  CMD_TRIM_EXIT    = 5'h00;
  localparam logic [2:0]  CMD_BIT_LAST     = 3'h5;

  // Result update interval and settling times in nanoseconds, with their cycle counts.
  localparam int unsigned UPDATE_NS        = 260000;
  localparam int unsigned BAND_SETTLE_NS   = 600000;
  localparam int unsigned STEP_SETTLE_NS   = 1200000;
  localparam int unsigned UPDATE_CYC_DEF   = UPDATE_NS * CLK_MHZ / 1000;
  localparam int unsigned BAND_CYC_DEF     = BAND_SETTLE_NS * CLK_MHZ / 1000;
  localparam int unsigned STEP_CYC_DEF     = STEP_SETTLE_NS * CLK_MHZ / 1000;

  // Initialisation length after any reset release.
  localparam int unsigned INIT_CYCLES      = 16;

  // Lost magnet threshold in millivolts, and default sample resolution.
  localparam int unsigned LOST_MV          = 15;
  localparam int unsigned LSB_UV_DEF       = 100;

  // Step detection: a change larger than this many output codes.
  localparam int unsigned STEP_THR_DEF     = 256;

  // Output word and its diagnostic code outside the normal range.
  localparam int unsigned ANGLE_W          = 16;
  localparam logic [15:0] OUT_DIAG_CODE    = 16'hFFFF;
  localparam logic [15:0] OUT_NORM_MAX     = 16'hFFFE;
  localparam logic [15:0] ANGLE_RST        = 16'h0000;

  // Frame receiver states, one-hot.
  typedef enum logic [3:0] {
    TMSC_IDLE  = 4'h1,
    TMSC_BITS  = 4'h2,
    TMSC_STOP  = 4'h4,
    TMSC_CLOSE = 4'h8
  } tmsc_state_t;

endpackage

/* File: tmsc_link_if.sv */
// Purpose: Carrier between the bit clock capture and the system side.
// Assumes: Written in the bit clock domain, read after a toggle crossing.
// Notes:   The sample is stable for a whole bit clock period after a toggle.
`timescale 1ns/1ps
interface tmsc_link_if;
  logic edge_tgl;
  logic sel_sample;
  logic link_rst;

  modport cap  (output edge_tgl, output sel_sample, input link_rst);
  modport core (input edge_tgl, input sel_sample, output link_rst);
endinterface

/* File: tmsc_link_cap.sv */
// Purpose: Samples the trim select line on every rising bit clock edge.
// Assumes: Bit clock runs only while the programmer sends a frame.
// Notes:   Core reset clears this side at once, since the bit clock may stand still.
`timescale 1ns/1ps
module tmsc_link_cap (
  // Link clock and the select pin it times.
  input wire logic   trim_bit_clk,
  input wire logic   trim_select_line,
  // Toward the system side.
  tmsc_link_if.cap   lnk
);

  logic tgl_ff;
  logic smp_ff;

  // Each rising edge takes one bit and flips the toggle that announces it.
  // The bit clock stops between frames, so a reset synchronised on it would
  // release only on the next frame's edges and swallow its first bits. The
  // core reset is a glitch-free register and no frame runs while it is high,
  // so it clears this side directly.
  always_ff @(posedge trim_bit_clk or posedge lnk.link_rst) begin
    if (lnk.link_rst) begin
      tgl_ff <= 1'b0;
      smp_ff <= 1'b0;
    end else begin
      tgl_ff <= ~tgl_ff;
      smp_ff <= trim_select_line;
    end
  end

  assign lnk.edge_tgl   = tgl_ff;
  assign lnk.sel_sample = smp_ff;

endmodule

/* File: tmsc_props.sv */
// Purpose: Concurrent checks on the trim receiver's top-level ports.
// Assumes: Pin resets reach the core three clocks late; reset is synchronous.
// Notes:   Counters stand in for long repetitions.
`timescale 1ns/1ps
module tmsc_props import tmsc_pkg::*; #(
  parameter int unsigned UPDATE_CYCLES = UPDATE_CYC_DEF
) (
  // Clock and resets.
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               external_reset_input,
  input wire logic               supply_ok,
  // Observed outputs.
  input wire logic               trim_ch1_ff,
  input wire logic               trim_ch2_ff,
  input wire logic               frame_done_ff,
  input wire logic               test_out_ff,
  input wire logic               init_busy_ff,
  input wire logic               lost_magnet_ff,
  input wire logic               update_ff,
  input wire logic [ANGLE_W-1:0] out_code_ff
);
  logic [15:0] busy_cnt_ff;
  logic [15:0] gap_cnt_ff;
  logic        gap_ok_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Length of the current busy stretch, saturating so it cannot wrap.
  always_ff @(posedge clk) begin
    if (reset || !init_busy_ff) busy_cnt_ff <= 16'h0000;
    else if (busy_cnt_ff != 16'hFFFF) busy_cnt_ff <= busy_cnt_ff + 16'h0001;
  end

  // Cycles since the last update pulse.
  always_ff @(posedge clk) begin
    if (reset || init_busy_ff || update_ff) gap_cnt_ff <= 16'h0000;
    else gap_cnt_ff <= gap_cnt_ff + 16'h0001;
  end

  // The first pulse after init has no predecessor, so it only arms the check.
  always_ff @(posedge clk) begin
    if (reset || init_busy_ff) gap_ok_ff <= 1'b0;
    else if (update_ff) gap_ok_ff <= 1'b1;
  end

  a_trim_one_hot: assert property (!(trim_ch1_ff && trim_ch2_ff))
    else $error("both trim modes active");
  a_mode_by_frame: assert property ($rose(trim_ch1_ff) || $rose(trim_ch2_ff) |->
    (frame_done_ff || $past(frame_done_ff)) or (##1 frame_done_ff))
    else $error("trim mode entered without a frame");
  a_frame_pulse_one: assert property (frame_done_ff |=> !frame_done_ff)
    else $error("frame pulse longer than one cycle");
  a_test_out_idle: assert property ((!trim_ch1_ff && !trim_ch2_ff)[*2] |-> !test_out_ff)
    else $error("test output moves outside trim");
  a_ext_pin_reset: assert property (external_reset_input[*5] |->
    init_busy_ff && !trim_ch1_ff && !trim_ch2_ff)
    else $error("external reset did not take hold");
  a_supply_reset: assert property ((!supply_ok)[*5] |->
    init_busy_ff && !trim_ch1_ff && !trim_ch2_ff)
    else $error("supply reset did not take hold");
  a_init_length: assert property ($fell(init_busy_ff) |-> busy_cnt_ff >= INIT_CYCLES)
    else $error("initialisation too short");
  a_update_period: assert property (update_ff && gap_ok_ff |->
    gap_cnt_ff == UPDATE_CYCLES - 1)
    else $error("update interval wrong");
  a_no_update_init: assert property (init_busy_ff |-> !update_ff)
    else $error("update during initialisation");
  a_lost_diag_code: assert property (lost_magnet_ff && $past(lost_magnet_ff) |->
    out_code_ff == OUT_DIAG_CODE)
    else $error("lost magnet without diagnostic code");

  c_enter_ch1: cover property (frame_done_ff && trim_ch1_ff);
  c_enter_ch2: cover property (frame_done_ff && trim_ch2_ff);
  c_lost:      cover property ($rose(lost_magnet_ff));
  c_square:    cover property ($rose(test_out_ff));
endmodule

bind tmsc_top tmsc_props #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_props (
  .clk(clk), .reset(reset), .external_reset_input(external_reset_input),
  .supply_ok(supply_ok), .trim_ch1_ff(trim_ch1_ff), .trim_ch2_ff(trim_ch2_ff),
  .frame_done_ff(frame_done_ff), .test_out_ff(test_out_ff), .init_busy_ff(init_busy_ff),
  .lost_magnet_ff(lost_magnet_ff), .update_ff(update_ff), .out_code_ff(out_code_ff));

/* File: tmsc_prog_model.sv */
// Purpose: Behavioural trim programmer driving select and bit clock.
// Assumes: Bit clock of 1 us; faster edges outrun the core's crossing.
// Notes:   The bit clock stands still between frames unless the clocks task runs it.
`timescale 1ns/1ps
module tmsc_prog_model (
  // Pins toward the device.
  output logic trim_select_line,
  output logic trim_bit_clk
);
  localparam int HALF = 500;

  // Both lines idle high.
  initial begin
    trim_select_line = 1'b1;
    trim_bit_clk     = 1'b1;
  end

  // Sends nbits of cmd, first bit from the MSB, then closes the frame.
  task automatic frame(input logic [4:0] cmd, input int nbits);
    trim_bit_clk = 1'b1;
    #HALF;
    trim_select_line = 1'b0;
    #HALF;
    for (int i = 0; i < nbits; i++) begin
      trim_bit_clk = 1'b0;
      #(HALF/2);
      trim_select_line = cmd[4-i];
      #(HALF/2);
      trim_bit_clk = 1'b1;
      #(HALF/2);
      if (i < nbits - 1) #(HALF/2);
    end
    trim_select_line = 1'b1;
    #(HALF/2);
    trim_bit_clk = 1'b0;
    #HALF;
  endtask

  // Free clock edges with select high; outside a frame the core ignores them.
  task automatic clocks(input int n);
    repeat (n) begin
      trim_bit_clk = 1'b0;
      #HALF;
      trim_bit_clk = 1'b1;
      #HALF;
    end
  endtask
endmodule

/* File: tb_top.sv */
// Purpose: Self-checking bench for the trim command receiver.
// Assumes: Short update and settle counts set by parameters.
// Notes:   Clock-domain inputs change on the falling clock edge.
`timescale 1ns/1ps
module tb_top import tmsc_pkg::*;;
  localparam int UPD = 20;
  localparam int STP = 60;
  logic clk, reset, external_reset_input, supply_ok, sample_valid;
  logic trim_select_line, trim_bit_clk;
  logic signed [15:0] sens1_sample, sens2_sample;
  logic [15:0] angle_in, out_code_ff;
  logic trim_ch1_ff, trim_ch2_ff, frame_done_ff, test_out_ff;
  logic init_busy_ff, lost_magnet_ff, update_ff, settled_ff;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  tmsc_top #(.UPDATE_CYCLES(UPD), .BAND_CYCLES(30), .STEP_CYCLES(STP)) DUT (
    .clk(clk), .reset(reset), .external_reset_input(external_reset_input),
    .supply_ok(supply_ok), .trim_select_line(trim_select_line),
    .trim_bit_clk(trim_bit_clk), .sens1_sample(sens1_sample), .sens2_sample(sens2_sample),
    .sample_valid(sample_valid), .angle_in(angle_in), .trim_ch1_ff(trim_ch1_ff),
    .trim_ch2_ff(trim_ch2_ff), .frame_done_ff(frame_done_ff), .test_out_ff(test_out_ff),
    .init_busy_ff(init_busy_ff), .lost_magnet_ff(lost_magnet_ff), .update_ff(update_ff),
    .settled_ff(settled_ff), .out_code_ff(out_code_ff));
  tmsc_prog_model prog (.trim_select_line(trim_select_line), .trim_bit_clk(trim_bit_clk));

  // 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up();
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  // A hang ends the run as a failure.
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wait_flag(input bit upd);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((upd ? update_ff : !init_busy_ff) !== 1'b1 && n < 100);
    chk(n < 100, 1'b1, "bounded wait ran out");
  endtask

  task automatic feed(input logic signed [15:0] s1, input logic signed [15:0] s2);
    @(negedge clk);
    sens1_sample = s1;
    sens2_sample = s2;
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
  endtask

  task automatic send(input logic [4:0] cmd, input int nbits, input logic exp_done);
    logic got;
    got = 1'b0;
    // The accept pulse comes a few clocks after the last clock fall, while
    // the programmer is still idling, so watch during the whole frame.
    fork
      prog.frame(cmd, nbits);
      repeat (300) begin
        @(negedge clk);
        if (frame_done_ff === 1'b1) got = 1'b1;
      end
    join
    chk(got, exp_done, "frame accept pulse");
  endtask

  task automatic t_square(input bit ch2);
    int tog;
    logic last;
    tog = 0;
    last = test_out_ff;
    for (int k = 0; k < 8; k++) begin
      if (ch2) feed(16'sh03E8, k[0] ? 16'sh03E8 : -16'sh03E8);
      else feed(k[0] ? 16'sh03E8 : -16'sh03E8, 16'sh03E8);
      repeat (6) begin
        @(negedge clk);
        if (test_out_ff !== last) tog++;
        last = test_out_ff;
      end
    end
    chk(tog > 0, 1'b1, "no square wave in trim");
  endtask

  task automatic t_modes();
    send(CMD_TRIM_CH1, 5, 1'b1);
    chk(trim_ch1_ff, 1'b1, "channel 1 trim not entered");
    chk(trim_ch2_ff, 1'b0, "channel 2 trim set");
    t_square(1'b0);
    send(CMD_TRIM_CH2, 5, 1'b1);
    chk(trim_ch2_ff, 1'b1, "channel 2 trim not entered");
    chk(trim_ch1_ff, 1'b0, "channel 1 trim kept");
    t_square(1'b1);
  endtask

  task automatic t_refuse();
    send(5'h0C, 5, 1'b0);
    chk(trim_ch2_ff, 1'b1, "undefined command changed mode");
    send(CMD_TRIM_CH1, 3, 1'b0);
    chk(trim_ch2_ff, 1'b1, "partial frame changed mode");
    chk(trim_ch1_ff, 1'b0, "partial frame entered channel 1");
    send(CMD_TRIM_EXIT, 5, 1'b1);
    chk({trim_ch1_ff, trim_ch2_ff}, 2'h0, "exit command ignored");
    chk(test_out_ff, 1'b0, "test output left high");
  endtask

  task automatic t_pin_reset(input bit use_supply);
    send(CMD_TRIM_CH1, 5, 1'b1);
    @(negedge clk);
    if (use_supply) supply_ok = 1'b0;
    else external_reset_input = 1'b1;
    prog.clocks(3);
    chk(trim_ch1_ff, 1'b0, "reset kept trim mode");
    chk(init_busy_ff, 1'b1, "reset did not restart init");
    @(negedge clk);
    supply_ok = 1'b1;
    external_reset_input = 1'b0;
    wait_flag(1'b0);
  endtask

  task automatic t_lost();
    feed(16'sh0095, -16'sh0095);
    repeat (3) @(negedge clk);
    chk(lost_magnet_ff, 1'b1, "lost magnet not flagged");
    chk(out_code_ff, OUT_DIAG_CODE, "no diagnostic code");
    feed(16'sh0096, 16'sh0000);
    repeat (3) @(negedge clk);
    chk(lost_magnet_ff, 1'b0, "lost magnet at threshold");
  endtask

  task automatic t_measure();
    angle_in = 16'h1234;
    wait_flag(1'b1);
    wait_flag(1'b1);
    repeat (3) @(negedge clk);
    chk(out_code_ff, 16'h1234, "angle not updated");
    angle_in = 16'hFFFF;
    wait_flag(1'b1);
    repeat (3) @(negedge clk);
    chk(out_code_ff, OUT_NORM_MAX, "angle not clipped");
    repeat (STP + 3 * UPD) @(negedge clk);
    chk(settled_ff, 1'b1, "output never settled");
  endtask

  // Main sequence; the pin reset is held while the link side gets its edges.
  initial begin
    reset = 1'b1;
    external_reset_input = 1'b1;
    supply_ok = 1'b1;
    sample_valid = 1'b0;
    sens1_sample = 16'sh03E8;
    sens2_sample = 16'sh03E8;
    angle_in = 16'h0000;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    prog.clocks(3);
    chk(init_busy_ff, 1'b1, "init not busy in reset");
    chk(out_code_ff, ANGLE_RST, "output code reset value");
    chk({trim_ch1_ff, trim_ch2_ff}, 2'h0, "trim set out of reset");
    external_reset_input = 1'b0;
    wait_flag(1'b0);
    t_modes();
    t_refuse();
    t_pin_reset(1'b0);
    t_pin_reset(1'b1);
    t_lost();
    t_measure();
    wrap_up();
  end
endmodule
